// ---- osdld_defs.vh ----
// constants for the on-screen display list decoder
// Functional notes
// RULE1 - display enable is bit 0 at 31H
// RULE2 - software enables display after transfers, during retrace
// RULE3 - software writes list only while display disabled
// RULE4 - entry is even nibble high, odd low
// RULE5 - list spans banks two to five, 224 entries
// RULE6 - top two bits type, low six payload
// RULE7 - types: pattern, control, bank select, return
// RULE8 - pattern payload drives rom address bits 9..4
// RULE9 - rom bank drives upper rom address bits
// RULE10 - pattern is fifteen words, nibbles 0 to E
// RULE11 - return ends line, gives next line start
// RULE12 - two returns in a row end screen
// RULE13 - return payload: row, column 3..1, bit0 zero
// RULE14 - return target ignores list bank number
// RULE15 - rom bank held until next bank select
// RULE16 - rom bank defaults zero, low payload bits select
// RULE17 - control payload bits 9..4, low bits ones
// RULE18 - control addressing also uses current rom bank
// RULE19 - transfers accepted only while transfer enable set
// RULE20 - processing starts at first entry of list
// RULE21 - display disabled means no fetches, no pixels
`ifndef OSDLD_DEFS_VH
`define OSDLD_DEFS_VH

// register file indices; byte address is four times the index
`define OSDLD_RF_XFER_IDX      8'h00
`define OSDLD_RF_ENABLE_IDX    8'h31
`define OSDLD_RF_STATUS_IDX    8'h32
`define OSDLD_ADDR_XFER        {2'b00, `OSDLD_RF_XFER_IDX, 2'b00}
`define OSDLD_ADDR_ENABLE      {2'b00, `OSDLD_RF_ENABLE_IDX, 2'b00}
`define OSDLD_ADDR_STATUS      {2'b00, `OSDLD_RF_STATUS_IDX, 2'b00}

// field positions
`define OSDLD_XFER_EN_BIT      1
`define OSDLD_DISP_EN_BIT      0

// list geometry
`define OSDLD_LIST_ENTRIES     224
`define OSDLD_LAST_ROW         3'h6
`define OSDLD_LAST_BANK        2'h3
`define OSDLD_LAST_COL         3'h7

// entry types
`define OSDLD_TYPE_PATTERN     2'h0
`define OSDLD_TYPE_RETURN      2'h1
`define OSDLD_TYPE_CONTROL     2'h2
`define OSDLD_BANK_SEL_CODE    3'h7

// rom fetch
`define OSDLD_PATTERN_LAST     4'he
`define OSDLD_CONTROL_LOW      4'hf

// reset values
`define OSDLD_ROM_BANK_RESET   2'h0
`define OSDLD_PTR_START        8'h00

`endif

// ---- osdld_entry_class.v ----
// classifies one display-list entry by its type field
`timescale 1ns/1ps
`include "osdld_defs.vh"
module osdld_entry_class (
  input  wire [7:0] entry,
  output reg        isPattern,
  output reg        isControl,
  output reg        isBankSel,
  output reg        isReturn
);
  always @* begin
    isPattern = 1'b0;
    isControl = 1'b0;
    isBankSel = 1'b0;
    isReturn  = 1'b0;
    case (entry[7:6]) // RULE6
      `OSDLD_TYPE_PATTERN: isPattern = 1'b1; // RULE7
      `OSDLD_TYPE_CONTROL: isControl = 1'b1; // RULE7
      `OSDLD_TYPE_RETURN: begin
        if (entry[5:3] == `OSDLD_BANK_SEL_CODE) begin
          isBankSel = 1'b1; // RULE7
        end else begin
          isReturn = 1'b1; // RULE7
        end
      end
      // prohibited type: none set, entry is stepped over
      default: isPattern = 1'b0;
    endcase
  end
endmodule

// ---- osdld_rom_model.sv ----
// character rom stand-in for the decoder's fetch port
`timescale 1ns/1ps
module osdld_rom_model (
  input  wire logic        clock,
  input  wire logic [11:0] romAddr,
  input  wire logic        romRead,
  output logic      [15:0] romData
);
  logic liveQ = 1'b0;
  always @(posedge clock) liveQ <= romRead;
  // word stands for the read cycle and the next; inverted otherwise so a
  // late sample never matches by luck
  assign romData = (romRead | liveQ) ? {4'ha, romAddr} : ~{4'ha, romAddr};
endmodule

// ---- osdld_sync3.v ----
// three-stage synchroniser for a pin level, change taken when stages agree
`timescale 1ns/1ps
module osdld_sync3 (
  input  wire clock,
  input  wire reset_n,
  input  wire pinIn,
  output reg  levelOut
);
  reg stage1_q;
  reg stage2_q;
  reg stage3_q;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q <= 1'b1;
      stage2_q <= 1'b1;
      stage3_q <= 1'b1;
      levelOut <= 1'b1;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      if (stage2_q == stage3_q) begin
        levelOut <= stage3_q;
      end
    end
  end
endmodule

// ---- osdld_top.v ----
// display-list decoder with apb register file and list storage
`timescale 1ns/1ps
`include "osdld_defs.vh"
module osdld_top (
  input  wire        clock,
  input  wire        reset_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        vsyncPin,
  input  wire        dmaRequest,
  input  wire [15:0] romData,
  output reg         dmaGrant,
  output reg  [11:0] romAddr,
  output reg         romRead,
  output reg  [15:0] pixelWord,
  output reg         pixelValid,
  output reg  [15:0] controlWord,
  output reg         controlValid,
  output reg         lineEnd,
  output reg         frameEnd
);
  localparam ST_IDLE  = 5'b00001;
  localparam ST_ARM   = 5'b00010;
  localparam ST_FETCH = 5'b00100;
  localparam ST_ROM   = 5'b01000;
  localparam ST_DONE  = 5'b10000;

  // pointer layout: {list bank, row, column bits 3..1}
  function [7:0] entryIndex;
    input [7:0] ptr;
    begin
      entryIndex = {ptr[7:6], 5'b00000} + {1'b0, ptr[7:6], 4'b0000}
                 + {2'b00, ptr[7:6], 3'b000} + {2'b00, ptr[5:0]};
    end
  endfunction

  function [8:0] nextPtr;
    input [7:0] ptr;
    begin
      if (ptr[2:0] != `OSDLD_LAST_COL) begin
        nextPtr = {1'b0, ptr[7:3], ptr[2:0] + 3'h1};
      end else if (ptr[5:3] != `OSDLD_LAST_ROW) begin
        nextPtr = {1'b0, ptr[7:6], ptr[5:3] + 3'h1, 3'h0};
      end else if (ptr[7:6] != `OSDLD_LAST_BANK) begin
        nextPtr = {1'b0, ptr[7:6] + 2'h1, 6'h00};
      end else begin
        // bit 8 flags a walk past the end of storage
        nextPtr = {1'b1, `OSDLD_PTR_START};
      end
    end
  endfunction

  reg  [7:0]  listMem [0:`OSDLD_LIST_ENTRIES-1]; // RULE5
  reg         xferEnable_q;
  reg         dispEnable_q;
  reg  [4:0]  state_q;
  reg  [7:0]  ptr_q;
  reg  [1:0]  romBank_q;
  reg  [7:0]  romBase_q;
  reg  [3:0]  wordCnt_q;
  reg         ctrlKind_q;
  reg         prevReturn_q;
  reg  [31:0] readMux;
  reg         mapped;

  wire        vsyncLevel;
  wire        retrace = ~vsyncLevel;
  wire [7:0]  curEntry = listMem[entryIndex(ptr_q)];
  wire [8:0]  stepPtr = nextPtr(ptr_q);
  wire        isPattern;
  wire        isControl;
  wire        isBankSel;
  wire        isReturn;

  // apb window for list nibbles: paddr[11] set, paddr[10:3] = bank,row,col, paddr[2] selects the low nibble
  wire        inWindow = paddr[11];
  wire [7:0]  winPtr = {paddr[10:6], paddr[5:3]};
  wire        winRowOk = (paddr[8:6] <= `OSDLD_LAST_ROW);
  wire        winLow = paddr[2];
  wire [7:0]  winEntry = listMem[entryIndex(winPtr)];
  wire        accessEnd = psel & penable & pready;
  wire        doWrite = accessEnd & pwrite & mapped;

  osdld_sync3 u_vsync (
    .clock    (clock),
    .reset_n  (reset_n),
    .pinIn    (vsyncPin),
    .levelOut (vsyncLevel)
  );

  osdld_entry_class u_class (
    .entry     (curEntry),
    .isPattern (isPattern),
    .isControl (isControl),
    .isBankSel (isBankSel),
    .isReturn  (isReturn)
  );

  always @* begin
    readMux = 32'h0000_0000;
    mapped  = 1'b1;
    if (inWindow) begin
      mapped = winRowOk;
      if (winRowOk) begin
        readMux = {28'h0000000, winLow ? winEntry[3:0] : winEntry[7:4]};
      end
    end else if (paddr == `OSDLD_ADDR_XFER) begin
      readMux[`OSDLD_XFER_EN_BIT] = xferEnable_q;
    end else if (paddr == `OSDLD_ADDR_ENABLE) begin
      readMux[`OSDLD_DISP_EN_BIT] = dispEnable_q; // RULE1
    end else if (paddr == `OSDLD_ADDR_STATUS) begin
      readMux = {27'h0000000, state_q == ST_DONE, romBank_q,
                 state_q != ST_IDLE, vsyncLevel};
    end else begin
      mapped = 1'b0;
    end
  end

  // apb slave: one wait state, so the access phase lasts two cycles
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready       <= 1'b0;
      pslverr      <= 1'b0;
      prdata       <= 32'h0000_0000;
      xferEnable_q <= 1'b0;
      dispEnable_q <= 1'b0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready  <= 1'b1;
        pslverr <= ~mapped;
        prdata  <= pwrite ? 32'h0000_0000 : readMux;
      end
      if (doWrite && !inWindow) begin
        if (paddr == `OSDLD_ADDR_XFER) begin
          xferEnable_q <= pwdata[`OSDLD_XFER_EN_BIT];
        end
        if (paddr == `OSDLD_ADDR_ENABLE) begin
          dispEnable_q <= pwdata[`OSDLD_DISP_EN_BIT]; // RULE1
        end
      end
    end
  end

  // list storage is plain flops with no reset; contents undefined at start
  always @(posedge clock) begin
    if (doWrite && inWindow) begin
      if (winLow) begin
        listMem[entryIndex(winPtr)][3:0] <= pwdata[3:0]; // RULE4
      end else begin
        listMem[entryIndex(winPtr)][7:4] <= pwdata[3:0]; // RULE4
      end
    end
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_q      <= ST_IDLE;
      ptr_q        <= `OSDLD_PTR_START;
      romBank_q    <= `OSDLD_ROM_BANK_RESET; // RULE16
      romBase_q    <= 8'h00;
      wordCnt_q    <= 4'h0;
      ctrlKind_q   <= 1'b0;
      prevReturn_q <= 1'b0;
      dmaGrant     <= 1'b0;
      romAddr      <= 12'h000;
      romRead      <= 1'b0;
      lineEnd      <= 1'b0;
      frameEnd     <= 1'b0;
    end else begin
      romRead  <= 1'b0;
      lineEnd  <= 1'b0;
      frameEnd <= 1'b0;
      // slots are granted one cycle after each request whenever transfers are on
      dmaGrant <= dmaRequest & xferEnable_q; // RULE19
      if (!dispEnable_q) begin
        state_q      <= ST_IDLE; // RULE21
        prevReturn_q <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (retrace) begin
              ptr_q   <= `OSDLD_PTR_START; // RULE20
              state_q <= ST_ARM;
            end
          end
          ST_ARM: begin
            if (!retrace) begin
              state_q <= ST_FETCH;
            end
          end
          ST_FETCH: begin
            if (dmaGrant) begin // RULE19
              if (isPattern || isControl) begin
                romBase_q    <= {romBank_q, curEntry[5:0]}; // RULE8 RULE17
                ctrlKind_q   <= isControl;
                wordCnt_q    <= 4'h0;
                prevReturn_q <= 1'b0;
                state_q      <= ST_ROM;
              end else if (isReturn) begin
                if (prevReturn_q) begin
                  frameEnd <= 1'b1; // RULE12
                  state_q  <= ST_DONE;
                end else begin
                  lineEnd      <= 1'b1; // RULE11
                  prevReturn_q <= 1'b1;
                  // list bank kept; only row and column come from payload
                  ptr_q <= {ptr_q[7:6], curEntry[5:3], curEntry[2:0]}; // RULE13 RULE14
                end
              end else begin
                if (isBankSel) begin
                  romBank_q <= curEntry[1:0]; // RULE15 RULE16
                end
                prevReturn_q <= 1'b0;
                ptr_q        <= stepPtr[7:0];
                if (stepPtr[8]) begin
                  frameEnd <= 1'b1;
                  state_q  <= ST_DONE;
                end
              end
            end
          end
          ST_ROM: begin
            if (dmaGrant) begin
              romRead <= 1'b1;
              if (ctrlKind_q) begin
                romAddr <= {romBase_q, `OSDLD_CONTROL_LOW}; // RULE17 RULE18
              end else begin
                romAddr <= {romBase_q, wordCnt_q}; // RULE9 RULE10
              end
              if (ctrlKind_q || wordCnt_q == `OSDLD_PATTERN_LAST) begin
                ptr_q <= stepPtr[7:0];
                if (stepPtr[8]) begin
                  frameEnd <= 1'b1;
                  state_q  <= ST_DONE;
                end else begin
                  state_q <= ST_FETCH;
                end
              end else begin
                wordCnt_q <= wordCnt_q + 4'h1; // RULE10
              end
            end
          end
          ST_DONE: begin
            if (retrace) begin
              ptr_q   <= `OSDLD_PTR_START; // RULE20
              state_q <= ST_ARM;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // rom answers in the same cycle as the read strobe
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pixelWord    <= 16'h0000;
      pixelValid   <= 1'b0;
      controlWord  <= 16'h0000;
      controlValid <= 1'b0;
    end else begin
      pixelValid   <= 1'b0;
      controlValid <= 1'b0;
      if (romRead && dispEnable_q) begin // RULE21
        if (ctrlKind_q) begin
          controlWord  <= romData;
          controlValid <= 1'b1;
        end else begin
          pixelWord  <= romData;
          pixelValid <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- osdld_top_monitor.sv ----
// assertions on the decoder's apb and rom fetch ports
`timescale 1ns/1ps
module osdld_top_monitor (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        dmaRequest,
  input wire logic        dmaGrant,
  input wire logic [11:0] romAddr,
  input wire logic        romRead,
  input wire logic        pixelValid,
  input wire logic        controlValid,
  input wire logic        lineEnd,
  input wire logic        frameEnd
);
  logic [3:0] prevNib_q;
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) prevNib_q <= 4'hf;
    else if (romRead) prevNib_q <= romAddr[3:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  access_ready_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered next cycle");
  error_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  grant_cause_a: assert property (dmaGrant |-> $past(dmaRequest))
    else $error("grant without request");
  read_grant_a: assert property (romRead |-> $past(dmaGrant))
    else $error("rom fetch outside a granted slot");
  pixel_follow_a: assert property (romRead && romAddr[3:0] != 4'hf
    |=> pixelValid && !controlValid)
    else $error("pattern word not delivered");
  control_follow_a: assert property (romRead && romAddr[3:0] == 4'hf
    |=> controlValid && !pixelValid)
    else $error("control word not delivered");
  pixel_cause_a: assert property (pixelValid |-> $past(romRead))
    else $error("pixel word without fetch");
  end_once_a: assert property (lineEnd |-> !frameEnd)
    else $error("line end and screen end together");
  nibble_step_a: assert property (romRead && prevNib_q < 4'he
    |-> romAddr[3:0] == prevNib_q + 4'h1)
    else $error("pattern words not consecutive");
endmodule
bind osdld_top osdld_top_monitor mon (.clock, .reset_n, .psel, .penable,
  .pready, .pslverr, .dmaRequest, .dmaGrant, .romAddr, .romRead,
  .pixelValid, .controlValid, .lineEnd, .frameEnd);

// ---- tb_top.sv ----
// testbench: list load, two frames walked against a list model
`timescale 1ns/1ps
module tb_top;
  logic        clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, vsyncPin = 1'b1, dmaRequest = 1'b0, er;
  logic [11:0] paddr = '0, romAddr;
  logic [31:0] pwdata = '0, rd, prdata;
  logic [15:0] romData, pixelWord, controlWord;
  logic        pready, pslverr, dmaGrant, romRead, pixelValid;
  logic        controlValid, lineEnd, frameEnd;
  logic [7:0]  lst [224];
  logic [11:0] expQ [$];
  logic [15:0] wq [$];
  int          err_count = 0, tests_run = 0, lineCnt = 0, frameCnt = 0;
  int          expLine = 0, expFrame = 0;
  int          idx [12] = '{0, 1, 2, 3, 4, 5, 8, 9, 16, 17, 18, 19};
  logic [7:0]  val [12] = '{8'h05, 8'h7a, 8'h83, 8'h7f, 8'h3f, 8'h48,
                            8'h01, 8'h53, 8'h02, 8'h02, 8'h02, 8'h40};
  osdld_top uut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .vsyncPin, .dmaRequest, .romData,
    .dmaGrant, .romAddr, .romRead, .pixelWord, .pixelValid, .controlWord,
    .controlValid, .lineEnd, .frameEnd);
  osdld_rom_model rom (.clock, .romAddr, .romRead, .romData);
  initial forever #50 clock = ~clock;
  always @(posedge clock) dmaRequest <= ($urandom % 4) != 0;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask
  always @(posedge clock) begin
    if (pixelValid === 1'b1) chk(pixelWord, wq.pop_front());
    if (controlValid === 1'b1) chk(controlWord, wq.pop_front());
    if (romRead === 1'b1) begin
      wq.push_back({4'ha, expQ.size() ? expQ[0] : 12'hfff});
      chk(romAddr, expQ.size() ? expQ.pop_front() : 12'hfff);
    end
    lineCnt += (lineEnd === 1'b1);
    frameCnt += (frameEnd === 1'b1);
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock) penable <= 1'b1;
    do begin @(posedge clock); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, pready, 1'b1);
      err_count++;
    end
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic put(input int p, input logic [7:0] e);
    logic [11:0] a;
    a = 12'h800 + 12'((p / 56) * 512 + ((p % 56) / 8) * 64 + (p % 8) * 8);
    lst[p] = e;
    apb(1'b1, a, {28'h0, e[7:4]}, rd, er);
    apb(1'b1, a + 12'h4, {28'h0, e[3:0]}, rd, er);
  endtask
  // list model: walks entries as the decoder must, logging rom addresses
  task automatic build(input int frames);
    int p, bk, prev;
    logic [7:0] e;
    bk = 0;
    repeat (frames) begin
      p = 0; prev = 0;
      while (p < 224) begin
        e = lst[p];
        if (e[7:6] == 2'h1 && e[5:3] == 3'h7) begin
          bk = e[1:0]; prev = 0; p++;
        end else if (e[7:6] == 2'h1) begin
          if (prev) begin expFrame++; break; end
          expLine++; prev = 1;
          p = (p / 56) * 56 + e[5:3] * 8 + e[2:0];
        end else begin
          if (e[7:6] == 2'h0)
            for (int i = 0; i < 15; i++) expQ.push_back(12'(bk*1024 + e[5:0]*16 + i));
          if (e[7:6] == 2'h2) expQ.push_back(12'(bk*1024 + e[5:0]*16 + 15));
          prev = 0; p++;
        end
      end
    end
  endtask
  task automatic waitFrame(input int f);
    int n;
    n = 0;
    while (frameCnt < f && n < 20000) begin @(posedge clock); n++; end
    if (frameCnt < f) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, frameCnt, f);
      err_count++;
    end
    vsyncPin <= 1'b0;
    repeat (8) @(posedge clock);
    vsyncPin <= 1'b1;
  endtask
  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(100 * 60000);
    err_count++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'hc26d8055));
    foreach (lst[i]) lst[i] = 8'h00;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    apb(1'b0, 12'h000, '0, rd, er); chk(rd, 32'h0);
    apb(1'b0, 12'h0c4, '0, rd, er); chk(rd, 32'h0);
    apb(1'b1, 12'h400, 32'h1, rd, er); chk(er, 32'h1);
    apb(1'b1, 12'h000, 32'h2, rd, er);
    repeat (30) @(posedge clock);
    foreach (idx[i]) put(idx[i], val[i]);
    build(2);
    vsyncPin <= 1'b0;
    repeat (8) @(posedge clock);
    apb(1'b1, 12'h0c4, 32'h1, rd, er);
    apb(1'b0, 12'h0c4, '0, rd, er); chk(rd, 32'h1);
    vsyncPin <= 1'b1;
    waitFrame(1);
    waitFrame(2);
    apb(1'b1, 12'h0c4, '0, rd, er);
    apb(1'b0, 12'h0c8, '0, rd, er); chk(rd[3:2], 32'h3);
    apb(1'b0, 12'h804, '0, rd, er); chk(rd[3:0], 32'h5);
    chk(expQ.size(), 32'h0);
    chk(lineCnt, expLine);
    chk(frameCnt, expFrame);
    report_and_stop;
  end
endmodule
